// ==== serial_port_four_mode.sv ====
// four-mode serial port core with avalon-mm registers
//
// Summary of operation
// R01: mode 0 moves data on pin a, shift clock on pin b, 8 bits lsb first.
// R02: mode 0 buffer write loads marker one; send starts one machine cycle later.
// R03: mode 0 clock low s3-s5, high s6-s2; shift right at s6.
// R04: mode 0 zeros fill left; marker left of msb ends send, sets transmit flag.
// R05: mode 0 receive starts on enable with flag clear; loads 11111110.
// R06: mode 0 receive samples at s5, shifts left at s6.
// R07: mode 0 zero reaching left end loads buffer, sets receive flag at s1.
// R08: mode 1 frame is start, 8 data lsb first, stop; stop stored.
// R09: mode 1 bit rate comes from baud timer overflow.
// R10: mode 1 write loads one in ninth place; send on next counter rollover.
// R11: send drives start bit, data enabled one bit later, shifts after.
// R12: mode 1 final shift, send drop and transmit flag at 10th rollover.
// R13: async receive samples at 16x; falling edge resets counter, loads ones.
// R14: bit value is majority of samples at counter states 7, 8, 9; the code samples at counter values 6, 7, 8.
// R15: non-zero start bit resets receiver to edge search.
// R16: mode 1 buffer load only when flag clear and stop bit allowed.
// R17: after final shift the receiver always returns to edge search.
// R18: mode 2/3 frame adds a software ninth bit before the stop bit.
// R19: mode 2 fixed rate from cpu clock; mode 3 uses baud timer.
// R20: mode 2/3 write loads ninth transmit bit; receive as mode 1.
// R21: mode 2/3 first shift inserts stop one; end at 11th rollover.
// R22: mode 2/3 buffer load only when flag clear and ninth bit allowed.
// R23: baud double bit zero gives mode 2 rate of clock over 32.
// R24: hardware only sets both flags; software clears them.
// R25: async transmit line rests high when idle.
`timescale 1ns/1ps
`default_nettype none
module serial_port_four_mode (
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [3:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  input  wire logic        i_port_pin_a,
  output logic             o_port_pin_a,
  output logic             o_port_pin_a_oe,
  output logic             o_port_pin_b
);
  import serial_port_pkg::*;

  typedef enum {RX_IDLE, RX_M0_ARM, RX_M0_LOAD, RX_M0_RUN, RX_M0_FIN, RX_ASYNC} rx_state_t;

  function automatic logic maj3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = v[7-i];
    end
  endfunction

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic [7:0] ctrl_q, buf_rx_q, baud_q;
  logic       dbl_q, wait_q;
  logic [31:0] rdata_q;
  logic       take, wr_ctrl, wr_buf;
  logic [1:0] mode;
  logic       ri_set, ti_set, rb8_set, rb8_val;

  assign take    = (i_read | i_write) & ~wait_q;
  assign wr_ctrl = take & i_write & i_byteenable[0] & (i_address == OFF_CTRL);
  assign wr_buf  = take & i_write & i_byteenable[0] & (i_address == OFF_BUF);
  assign mode    = ctrl_q[MODE_HI:MODE_LO];

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~((i_read | i_write) & wait_q);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rdata_q <= 32'h0;
    end else if (i_read & wait_q) begin
      case (i_address)
        OFF_CTRL:  rdata_q <= {24'h0, ctrl_q};
        OFF_BUF:   rdata_q <= {24'h0, buf_rx_q};
        OFF_POWER: rdata_q <= {31'h0, dbl_q};
        OFF_BAUD:  rdata_q <= {24'h0, baud_q};
        default:   rdata_q <= 32'h0;
      endcase
    end
  end

  // control register; hardware set wins over software clear
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ctrl_q <= CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= i_writedata[7:0];
      end
      if (ti_set) begin
        ctrl_q[TI_BIT] <= 1'b1; // R24
      end
      if (ri_set) begin
        ctrl_q[RI_BIT] <= 1'b1; // R24
      end
      if (rb8_set) begin
        ctrl_q[RB8_BIT] <= rb8_val;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      dbl_q  <= 1'b0; // R23
      baud_q <= BAUD_RST;
    end else begin
      if (take & i_write & i_byteenable[0] & (i_address == OFF_POWER)) begin
        dbl_q <= i_writedata[DBL_BIT];
      end
      if (take & i_write & i_byteenable[0] & (i_address == OFF_BAUD)) begin
        baud_q <= i_writedata[7:0];
      end
    end
  end

  // ----------------------------------------
  // machine cycle phases and baud timing
  // ----------------------------------------
  logic [2:0] ph_q;
  logic [7:0] btmr_q;
  logic       half_q, tick16;
  logic       bovf;

  assign bovf = (ph_q == PH_S6) & (btmr_q == 8'hff);

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ph_q <= PH_S1;
    end else begin
      ph_q <= (ph_q == PH_S6) ? PH_S1 : ph_q + 3'h1;
    end
  end

  // baud timer: auto-reload, counts machine cycles
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      btmr_q <= BAUD_RST;
    end else if (ph_q == PH_S6) begin
      btmr_q <= bovf ? baud_q : btmr_q + 8'h1;
    end
  end

  // halves the 16x tick unless doubled
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      half_q <= 1'b0;
    end else if ((mode[0] & bovf) | (mode == 2'h2)) begin
      half_q <= ~half_q;
    end
  end

  always_comb begin
    if (mode == 2'h2) begin
      tick16 = dbl_q | half_q; // R19 R23
    end else begin
      tick16 = bovf & (dbl_q | half_q); // R09 R19
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  logic [8:0] tx_sr_q;
  logic [3:0] tx_div_q;
  logic       tx_pend_q, tx_arm_q, send_q, data_q, first_q, fin_q;
  logic       roll, tx_last;

  assign roll    = tick16 & (tx_div_q == 4'hf);
  assign tx_last = (tx_sr_q[8:1] == TX_MARK);

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      tx_div_q <= 4'h0;
    end else if (tick16) begin
      tx_div_q <= tx_div_q + 4'h1; // R10
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      tx_sr_q   <= 9'h0;
      tx_pend_q <= 1'b0;
      tx_arm_q  <= 1'b0;
      send_q    <= 1'b0;
      data_q    <= 1'b0;
      first_q   <= 1'b0;
      fin_q     <= 1'b0;
    end else if (wr_buf) begin
      tx_sr_q   <= {(mode[1] ? ctrl_q[TB8_BIT] : 1'b1), i_writedata[7:0]}; // R02 R10 R20
      tx_pend_q <= 1'b1;
      tx_arm_q  <= 1'b0;
      send_q    <= 1'b0;
      data_q    <= 1'b0;
      first_q   <= 1'b1;
      fin_q     <= 1'b0;
    end else if (mode == MODE_SHIFT) begin
      if (fin_q & (ph_q == PH_S1)) begin
        send_q <= 1'b0; // R04
        fin_q  <= 1'b0;
      end else if (ph_q == PH_S6) begin
        if (tx_pend_q) begin
          tx_pend_q <= 1'b0;
          tx_arm_q  <= 1'b1;
        end else if (tx_arm_q) begin
          tx_arm_q <= 1'b0;
          send_q   <= 1'b1; // R02
        end else if (send_q & ~fin_q) begin
          tx_sr_q <= {1'b0, tx_sr_q[8:1]}; // R03 R04
          fin_q   <= tx_last;
        end
      end
    end else if (roll) begin
      if (tx_pend_q) begin
        tx_pend_q <= 1'b0;
        send_q    <= 1'b1; // R10 R11
      end else if (send_q & ~data_q) begin
        data_q <= 1'b1; // R11
      end else if (send_q) begin
        tx_sr_q <= {first_q & mode[1], tx_sr_q[8:1]}; // R21
        first_q <= 1'b0;
        // stop one not yet inserted: a low ninth bit could mimic the end pattern
        if (tx_last & ~first_q) begin
          send_q <= 1'b0; // R12 R21
          data_q <= 1'b0;
        end
      end
    end
  end

  assign ti_set = (mode == MODE_SHIFT) ? (fin_q & (ph_q == PH_S1))
                : (roll & send_q & data_q & tx_last & ~first_q);

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  logic       a_s1_q, a_s2_q, a_s3_q;
  rx_state_t  rx_q;
  logic [9:0] rsr_q;
  logic [3:0] rx_div_q;
  logic [1:0] smp_q;
  logic       m0_smp_q, first_bit_q;
  logic       fall, bit_ok, bit_v, rx_end, rx_ok, m0_end;
  logic [7:0] rx_data;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      a_s1_q <= 1'b1;
      a_s2_q <= 1'b1;
      a_s3_q <= 1'b1;
    end else begin
      a_s1_q <= i_port_pin_a;
      a_s2_q <= a_s1_q;
      a_s3_q <= a_s2_q;
    end
  end

  assign fall    = a_s3_q & ~a_s2_q;
  assign bit_ok  = tick16 & (rx_div_q == SMP_C);
  assign bit_v   = maj3(smp_q[1], smp_q[0], a_s2_q); // R14
  // only inside a frame; the divider keeps running while idle
  assign rx_end  = (rx_q == RX_ASYNC) & bit_ok & ~first_bit_q & ~(mode[1] ? rsr_q[9] : rsr_q[8]);
  assign rb8_val = mode[1] ? rsr_q[0] : bit_v;
  assign rx_data = mode[1] ? rev8(rsr_q[8:1]) : rev8(rsr_q[7:0]);
  assign rx_ok   = ~ctrl_q[RI_BIT] & (~ctrl_q[MPE_BIT] | rb8_val); // R16 R22
  assign m0_end  = (rx_q == RX_M0_RUN) & (ph_q == PH_S6) & ~rsr_q[7];

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rx_div_q <= 4'h0;
      smp_q    <= 2'h0;
    end else if ((rx_q == RX_IDLE) & fall) begin
      rx_div_q <= 4'h0; // R13
    end else if (tick16) begin
      rx_div_q <= rx_div_q + 4'h1;
      if (rx_div_q == SMP_A) begin
        smp_q[1] <= a_s2_q; // R14
      end
      if (rx_div_q == SMP_B) begin
        smp_q[0] <= a_s2_q;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      m0_smp_q <= 1'b1;
    end else if (ph_q == PH_S5) begin
      m0_smp_q <= a_s2_q; // R06
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rx_q        <= RX_IDLE;
      rsr_q       <= RX_INIT;
      first_bit_q <= 1'b0;
    end else begin
      case (rx_q)
        RX_IDLE: begin
          if (ctrl_q[REN_BIT] & (mode == MODE_SHIFT) & ~ctrl_q[RI_BIT] & ~send_q) begin
            rx_q <= RX_M0_ARM; // R05
          end else if (ctrl_q[REN_BIT] & (mode != MODE_SHIFT) & fall) begin
            rx_q        <= RX_ASYNC;
            rsr_q       <= RX_INIT; // R13
            first_bit_q <= 1'b1;
          end
        end
        RX_M0_ARM: begin
          if (ph_q == PH_S6) begin
            rsr_q <= {2'h3, M0_RX_INIT}; // R05
            rx_q  <= RX_M0_LOAD;
          end
        end
        RX_M0_LOAD: rx_q <= RX_M0_RUN;
        RX_M0_RUN: begin
          if (ph_q == PH_S6) begin
            rsr_q <= {rsr_q[8:0], m0_smp_q}; // R06
            if (~rsr_q[7]) begin
              rx_q <= RX_M0_FIN; // R07
            end
          end
        end
        RX_M0_FIN: begin
          if (ph_q == PH_S1) begin
            rx_q <= RX_IDLE; // R07
          end
        end
        RX_ASYNC: begin
          if (mode == MODE_SHIFT) begin
            rx_q <= RX_IDLE;
          end else if (bit_ok) begin
            first_bit_q <= 1'b0;
            if (first_bit_q & bit_v) begin
              rx_q <= RX_IDLE; // R15
            end else begin
              rsr_q <= {rsr_q[8:0], bit_v}; // R15
              if (rx_end) begin
                rx_q <= RX_IDLE; // R17
              end
            end
          end
        end
        default: rx_q <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      buf_rx_q <= 8'h0;
    end else if (m0_end) begin
      buf_rx_q <= rev8({rsr_q[6:0], m0_smp_q}); // R01 R07
    end else if (rx_end & rx_ok) begin
      buf_rx_q <= rx_data; // R08 R16 R18 R20
    end
  end

  assign ri_set  = ((rx_q == RX_M0_FIN) & (ph_q == PH_S1)) | (rx_end & rx_ok);
  assign rb8_set = rx_end & rx_ok; // R08 R18

  // ----------------------------------------
  // registered pin and bus outputs
  // ----------------------------------------
  logic pa_q, pa_oe_q, pb_q, m0_clk;
  logic recv0;

  assign recv0  = (rx_q == RX_M0_RUN) | (rx_q == RX_M0_FIN);
  assign m0_clk = ~((ph_q >= PH_S3) & (ph_q <= PH_S5)); // R03

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      pa_q    <= 1'b1;
      pa_oe_q <= 1'b0;
      pb_q    <= 1'b1;
    end else if (mode == MODE_SHIFT) begin
      pa_q    <= tx_sr_q[0]; // R01
      pa_oe_q <= send_q;
      pb_q    <= (send_q | recv0) ? m0_clk : 1'b1; // R01 R03 R06
    end else begin
      pa_q    <= 1'b1;
      pa_oe_q <= 1'b0;
      pb_q    <= ~send_q | (data_q & tx_sr_q[0]); // R11 R25
    end
  end

  assign o_port_pin_a    = pa_q;
  assign o_port_pin_a_oe = pa_oe_q;
  assign o_port_pin_b    = pb_q;
  assign o_readdata      = rdata_q;
  assign o_waitrequest   = wait_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  a_flag_set_wins: assert property (ri_set |=> ctrl_q[RI_BIT]) // R24
    else $error("receive flag lost on set");
  a_idle_line_high: assert property ((mode != MODE_SHIFT) & ~send_q ##1 (mode != MODE_SHIFT) |-> o_port_pin_b) // R25
    else $error("idle line not high");
  a_start_bit_low: assert property ((mode != MODE_SHIFT) & send_q & ~data_q ##1 (mode != MODE_SHIFT) |-> ~o_port_pin_b) // R11
    else $error("start bit not low");
  a_m0_marker_load: assert property (wr_buf & (mode == MODE_SHIFT) |=> tx_sr_q[8]) // R02
    else $error("marker not loaded");
  a_ninth_load: assert property (wr_buf & mode[1] |=> tx_sr_q[8] == $past(ctrl_q[TB8_BIT])) // R20
    else $error("ninth bit not loaded");
  a_fall_restart: assert property ((rx_q == RX_IDLE) & fall & ctrl_q[REN_BIT] & (mode != MODE_SHIFT)
    |=> rsr_q == RX_INIT && rx_div_q == 4'h0) // R13
    else $error("falling edge not handled");
  a_false_start: assert property ((rx_q == RX_ASYNC) & (mode != MODE_SHIFT) & bit_ok & first_bit_q & bit_v
    |=> rx_q == RX_IDLE) // R15
    else $error("false start kept");
  a_rx_gate: assert property (rx_end & ~rx_ok |=> $stable(buf_rx_q) && ctrl_q[RI_BIT] == $past(ctrl_q[RI_BIT])) // R16
    else $error("gated frame stored");
  a_m0_clk_low: assert property ((mode == MODE_SHIFT) & send_q & (ph_q == PH_S3) ##1 (mode == MODE_SHIFT)
    |-> ~o_port_pin_b) // R03
    else $error("shift clock high in s3");
  a_bus_answer: assert property ((i_read | i_write) & wait_q |=> ~o_waitrequest ##1 o_waitrequest)
    else $error("bus answer not one cycle");

  c_tx_done: cover property (ti_set & (mode != MODE_SHIFT));
  c_rx_ok: cover property (rx_end & rx_ok);
  c_false: cover property (bit_ok & first_bit_q & bit_v & (rx_q == RX_ASYNC));
  c_m0_rx: cover property (m0_end);
endmodule
`default_nettype wire

// ==== serial_port_pkg.sv ====
// constants for the four-mode serial port
package serial_port_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [3:0] OFF_CTRL  = 4'h0;
  localparam logic [3:0] OFF_BUF   = 4'h4;
  localparam logic [3:0] OFF_POWER = 4'h8;
  localparam logic [3:0] OFF_BAUD  = 4'hc;
  // ----------------------------------------
  // serial_control_reg fields, power register double bit and reset values
  // ----------------------------------------
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int MPE_BIT = 5;
  localparam int REN_BIT = 4;
  localparam int TB8_BIT = 3;
  localparam int RB8_BIT = 2;
  localparam int TI_BIT  = 1;
  localparam int RI_BIT  = 0;
  localparam int DBL_BIT = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  // ----------------------------------------
  // modes, phases, counters
  // ----------------------------------------
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_UART8 = 2'h1;
  localparam logic [2:0] PH_S1 = 3'h0;
  localparam logic [2:0] PH_S3 = 3'h2;
  localparam logic [2:0] PH_S5 = 3'h4;
  localparam logic [2:0] PH_S6 = 3'h5;
  localparam logic [3:0] SMP_A = 4'h6;
  localparam logic [3:0] SMP_B = 4'h7;
  localparam logic [3:0] SMP_C = 4'h8;
  localparam logic [7:0] M0_RX_INIT = 8'hfe;
  localparam logic [9:0] RX_INIT = 10'h3ff;
  localparam logic [7:0] TX_MARK = 8'h01;
endpackage

// ==== serial_peer.sv ====
// remote serial device model: async frames and mode 0 shift peripheral
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input  wire logic i_sys_clk,
  input  wire logic i_line,
  input  wire logic i_data,
  input  wire logic i_data_oe,
  output logic      o_line
);
  // ----------------------------------------
  // line helpers
  // ----------------------------------------
  // released line rests at the pull-up level
  initial o_line = 1'b1;

  task automatic wait_for(input logic lvl, output logic ok);
    int n;
    n = 0;
    while (i_line !== lvl && n < 4000) begin
      @(posedge i_sys_clk);
      n++;
    end
    ok = (i_line === lvl);
  endtask

  // ----------------------------------------
  // asynchronous frames
  // ----------------------------------------
  task automatic send_async(input logic [10:0] f, input int n, input int bt);
    @(posedge i_sys_clk);
    for (int i = 0; i < n; i++) begin
      o_line <= f[i];
      repeat (bt) @(posedge i_sys_clk);
    end
    o_line <= 1'b1;
  endtask

  task automatic glitch(input int w);
    @(posedge i_sys_clk);
    o_line <= 1'b0;
    repeat (w) @(posedge i_sys_clk);
    o_line <= 1'b1;
  endtask

  // samples mid-bit from the first falling edge
  task automatic get_async(output logic [10:0] f, input int n, input int bt, output logic ok);
    f = '0;
    wait_for(1'b0, ok);
    repeat (bt / 2) @(posedge i_sys_clk);
    for (int i = 0; i < n; i++) begin
      f[i] = i_line;
      repeat (bt) @(posedge i_sys_clk);
    end
  endtask

  // ----------------------------------------
  // mode 0 shift peripheral
  // ----------------------------------------
  task automatic m0_get(output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    d = '0;
    while (i_data_oe !== 1'b1 && n < 200) begin
      @(posedge i_sys_clk);
      n++;
    end
    for (int i = 0; i < 8; i++) begin
      wait_for(1'b0, ok);
      d[i] = i_data;
      wait_for(1'b1, ok);
    end
  endtask

  // next bit after each rising clock, stable through the low phase
  task automatic m0_feed(input logic [7:0] d, output logic ok);
    o_line <= d[0];
    for (int i = 1; i < 9; i++) begin
      wait_for(1'b0, ok);
      wait_for(1'b1, ok);
      o_line <= (i < 8) ? d[i] : 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// ==== serial_port_four_mode_tb.sv ====
// self-checking bench for the four-mode serial port
`timescale 1ns/1ps
`default_nettype none
module serial_port_four_mode_tb;
  import serial_port_pkg::*;
  logic        i_sys_clk;
  logic        i_sys_rst;
  logic [3:0]  i_address;
  logic        i_read;
  logic        i_write;
  logic [31:0] i_writedata;
  logic [3:0]  i_byteenable;
  logic [31:0] o_readdata;
  logic        o_waitrequest;
  logic        o_port_pin_a;
  logic        o_port_pin_a_oe;
  logic        o_port_pin_b;
  logic        peer_line;
  wire logic   pin_a_level;
  int          num_errors = 0;
  int          check_count = 0;
  int          cyc;

  // pin a carries the device's data while it drives, else the peer's
  assign pin_a_level = o_port_pin_a_oe ? o_port_pin_a : peer_line;

  serial_port_four_mode u_serial_port_four_mode (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_port_pin_a(pin_a_level),
    .o_port_pin_a(o_port_pin_a), .o_port_pin_a_oe(o_port_pin_a_oe), .o_port_pin_b(o_port_pin_b));

  serial_peer u_serial_peer (
    .i_sys_clk(i_sys_clk), .i_line(o_port_pin_b), .i_data(o_port_pin_a),
    .i_data_oe(o_port_pin_a_oe), .o_line(peer_line));

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [10:0] g, input logic [10:0] e, input string s);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_address   <= a;
    i_writedata <= {24'h000000, d};
    i_write     <= wr;
    i_read      <= ~wr;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 50);
    q = o_readdata[7:0];
    i_write <= 1'b0;
    i_read  <= 1'b0;
    chk(n < 50, 1'b1, "bus answer");
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m, input string s);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q & m, e & m, s);
  endtask

  task automatic cfg(input logic [1:0] md, input logic [5:0] low, input logic dbl, input logic [7:0] rl);
    wr(OFF_POWER, {7'h00, dbl});
    wr(OFF_BAUD, rl);
    wr(OFF_CTRL, {md, low});
  endtask

  function automatic int bit_time(input logic [1:0] md, input logic dbl, input logic [7:0] rl);
    if (md == 2'h2) return 32 >> dbl;
    return (192 * (256 - rl)) >> dbl;
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(o_port_pin_b, 1'b1, "idle line");
    chk(o_port_pin_a_oe, 1'b0, "pin a released");
    rd_chk(OFF_CTRL, CTRL_RST, 8'hff, "ctrl reset");
    rd_chk(OFF_POWER, 8'h00, 8'hff, "power reset");
    wr(4'h2, 8'h5a);
    rd_chk(4'h2, 8'h00, 8'hff, "unmapped");
  endtask

  task automatic t_tx(input logic [1:0] md, input logic dbl, input logic [7:0] rl, input logic [7:0] d,
                      input logic b9);
    logic [10:0] f;
    logic [10:0] e;
    logic        ok;
    int          bt;
    bt = bit_time(md, dbl, rl);
    cfg(md, {2'b00, b9, 3'b000}, dbl, rl);
    wr(OFF_BUF, d);
    u_serial_peer.get_async(f, (md == MODE_UART8) ? 10 : 11, bt, ok);
    e = (md == MODE_UART8) ? {2'b01, d, 1'b0} : {1'b1, b9, d, 1'b0};
    chk(ok, 1'b1, "start bit seen");
    chk(f, e, "tx frame");
    rd_chk(OFF_CTRL, 8'h02, 8'h02, "transmit flag set");
    chk(o_port_pin_b, 1'b1, "line back idle");
    wr(OFF_CTRL, {md, 6'h00});
    rd_chk(OFF_CTRL, 8'h00, 8'h02, "transmit flag cleared");
  endtask

  task automatic t_m0();
    logic [7:0] d;
    logic       ok;
    cfg(MODE_SHIFT, 6'h00, 1'b0, 8'h00);
    wr(OFF_BUF, 8'h6b);
    u_serial_peer.m0_get(d, ok);
    chk(d, 8'h6b, "mode 0 tx data");
    repeat (12) @(posedge i_sys_clk);
    chk(o_port_pin_a_oe, 1'b0, "mode 0 send dropped");
    rd_chk(OFF_CTRL, 8'h02, 8'h03, "mode 0 transmit flag");
    wr(OFF_CTRL, 8'h00);
    fork
      u_serial_peer.m0_feed(8'h94, ok);
      wr(OFF_CTRL, 8'h10);
    join
    repeat (12) @(posedge i_sys_clk);
    chk(ok, 1'b1, "mode 0 clock seen");
    rd_chk(OFF_BUF, 8'h94, 8'hff, "mode 0 rx data");
    rd_chk(OFF_CTRL, 8'h01, 8'h01, "mode 0 receive flag");
  endtask

  task automatic rx_frame(input logic [7:0] d, input logic b9, input int n, input int bt,
                          input logic [7:0] eb, input logic [7:0] ec, input logic [7:0] m);
    u_serial_peer.send_async({1'b1, b9, d, 1'b0}, n, bt);
    rd_chk(OFF_BUF, eb, 8'hff, "rx buffer");
    rd_chk(OFF_CTRL, ec, m, "rx flags");
  endtask

  task automatic t_rx();
    cfg(2'h2, 6'h10, 1'b0, 8'h00);
    rx_frame(8'hc3, 1'b1, 11, 32, 8'hc3, 8'h05, 8'h05);
    rx_frame(8'h18, 1'b1, 11, 32, 8'hc3, 8'h05, 8'h05);
    wr(OFF_CTRL, 8'hb0);
    rx_frame(8'h77, 1'b0, 11, 32, 8'hc3, 8'h00, 8'h01);
    rx_frame(8'h77, 1'b1, 11, 32, 8'h77, 8'h05, 8'h05);
    cfg(MODE_UART8, 6'h30, 1'b1, 8'hff);
    // new reload only takes hold at the next baud timer overflow
    repeat (1600) @(posedge i_sys_clk);
    rx_frame(8'h5e, 1'b0, 10, 96, 8'h77, 8'h00, 8'h01);
    rx_frame(8'h5e, 1'b1, 10, 96, 8'h5e, 8'h05, 8'h05);
    wr(OFF_CTRL, 8'h50);
    u_serial_peer.glitch(4);
    repeat (192) @(posedge i_sys_clk);
    rx_frame(8'ha1, 1'b1, 10, 96, 8'ha1, 8'h05, 8'h05);
  endtask

  // ----------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  initial begin
    cyc = 0;
    forever begin
      @(posedge i_sys_clk);
      cyc++;
      if (cyc == 60000) begin
        num_errors++;
        $display("CHECK FAILED at %0t: timeout", $time);
        finish_test();
      end
    end
  end

  initial begin
    i_sys_rst    = 1'b1;
    i_address    = 4'h0;
    i_read       = 1'b0;
    i_write      = 1'b0;
    i_writedata  = 32'h00000000;
    i_byteenable = 4'hf;
    repeat (3) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_tx(2'h2, 1'b0, 8'h00, 8'ha5, 1'b1);
    t_tx(2'h2, 1'b1, 8'h00, 8'h3c, 1'b0);
    t_tx(MODE_UART8, 1'b1, 8'hff, 8'h96, 1'b1);
    t_tx(2'h3, 1'b1, 8'hfe, 8'h4d, 1'b0);
    t_m0();
    t_rx();
    finish_test();
  end
endmodule
`default_nettype wire
